// [include/dcf_link_if.sv]
`timescale 1ns/1ps
interface dcf_link_if;
	logic frmValid;
	logic frmFirst;
	logic frmLast;
	dcf_pkg::dcf_byte_type frmData;
	logic ctlValid;
	dcf_pkg::dcf_byte_type ctlData;
	logic syncTick;

	modport dev (
		output frmValid,
		output frmFirst,
		output frmLast,
		output frmData,
		input ctlValid,
		input ctlData,
		input syncTick
	);
	modport host (
		input frmValid,
		input frmFirst,
		input frmLast,
		input frmData,
		output ctlValid,
		output ctlData,
		output syncTick
	);
endinterface

// [include/dcf_pkg.sv]
package dcf_pkg;
	typedef enum logic [1:0] {
		DCF_IDLE = 2'b00,
		DCF_HDR = 2'b01,
		DCF_PKT = 2'b11
	} dcf_state_type;
	typedef logic [7:0] dcf_byte_type;
	typedef logic [15:0] dcf_slice_type;
endpackage

// [include/dcf_regs.svh]
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define DCF_CLK_MHZ 50
`define DCF_SYNC_NS 1000
`define DCF_SYNC_CYC ((`DCF_SYNC_NS * `DCF_CLK_MHZ) / 1000)

// ----------------------------------------------------------------
// Frame header layout (bytes from frame start)
// ----------------------------------------------------------------
`define DCF_HDR_LEN 4'd8
`define DCF_SLICE_HI_POS 4'd6
`define DCF_SLICE_LO_POS 4'd7

// ----------------------------------------------------------------
// Appended measure packet layout
// ----------------------------------------------------------------
`define DCF_PKT_LEN 4'd12
`define DCF_PKT_LEN_POS 4'd0
`define DCF_PKT_CTR_POS 4'd1
`define DCF_PKT_PID_POS 4'd2
`define DCF_PKT_FILL_POS 4'd3
`define DCF_PKT_TS_POS 4'd4
`define DCF_PKT_DATA_POS 4'd8
`define DCF_FILL_BYTE 8'h00

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DCF_SLICE_RST 16'hffff
`define DCF_CTR_RST 8'h00

`endif

// [logic/dcf_chain_module.sv]
`timescale 1ns/1ps
`include "dcf_regs.svh"

module dcf_chain_module #(
	parameter int SLOT_BITS = 4,
	parameter logic [47:0] MAC_ADDR = 48'h02_00_00_00_00_01,
	parameter logic [7:0] PKT_ID = 8'h01
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	dcf_link_if.dev link,
	input wire logic upValid,
	input wire logic upFirst,
	input wire logic upLast,
	input wire logic [7:0] upData,
	input wire logic isLast,
	input wire logic genEnable,
	input wire logic [15:0] slicePeriod,
	input wire logic [(1 << SLOT_BITS) - 1:0] slotMask,
	input wire logic [31:0] measData,
	output logic ctlOutValid,
	output logic [7:0] ctlOutData,
	output logic [15:0] sliceNum
);
	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (SLOT_BITS < 1 || SLOT_BITS > 16) begin : gBadSlot
		$error("SLOT_BITS must be 1 to 16");
	end

	localparam logic [5:0] SYNC_LAST = 6'(`DCF_SYNC_CYC - 1);
	localparam logic [5:0] SYNC_HALF = 6'(`DCF_SYNC_CYC / 2);

	dcf_pkg::dcf_state_type state_q;
	dcf_pkg::dcf_slice_type sliceCnt_q, rxSlice_q, curSlice;
	logic [15:0] genCnt_q;
	logic [3:0] idx_q, pos_q, upPos;
	logic [5:0] usCnt_q;
	logic [31:0] timeUs_q, pktTs_q, pktData_q;
	logic [63:0] hdrWord;
	logic [7:0] ctr_q, hdrByte, pktByte;
	logic sliceTick_q, hit;

	// ----------------------------------------------------------------
	// Slice generator and counter
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			genCnt_q <= 16'h0000;
			sliceTick_q <= 1'b0;
		end else if (!(isLast && genEnable)) begin
			genCnt_q <= 16'h0000;
			sliceTick_q <= 1'b0;
		end else if (genCnt_q + 16'h0001 >= slicePeriod) begin
			genCnt_q <= 16'h0000;
			sliceTick_q <= 1'b1;
		end else begin
			genCnt_q <= genCnt_q + 16'h0001;
			sliceTick_q <= 1'b0;
		end
	end

	// First tick after reset yields slice zero; wraps naturally
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sliceCnt_q <= `DCF_SLICE_RST;
		end else if (sliceTick_q) begin
			sliceCnt_q <= sliceCnt_q + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Slice number taken from the upstream header
	// ----------------------------------------------------------------
	assign upPos = upFirst ? 4'h0 : pos_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pos_q <= 4'h0;
			rxSlice_q <= 16'h0000;
		end else if (upValid) begin
			pos_q <= (upPos == 4'hf) ? 4'hf : upPos + 4'h1;
			if (upPos == `DCF_SLICE_HI_POS) begin
				rxSlice_q[15:8] <= upData;
			end
			if (upPos == `DCF_SLICE_LO_POS) begin
				rxSlice_q[7:0] <= upData;
			end
		end
	end

	// Short frames end on the low slice byte itself
	assign curSlice = isLast ? sliceCnt_q
		: (upValid && upPos == `DCF_SLICE_LO_POS)
		? {rxSlice_q[15:8], upData} : rxSlice_q;

	// Mask holds the slot pattern repeating every 2**SLOT_BITS slices (low slice bits index it)
	assign hit =
		slotMask[curSlice[SLOT_BITS - 1:0]];

	// ----------------------------------------------------------------
	// Local timebase, realigned by the sync line
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			usCnt_q <= 6'h00;
			timeUs_q <= 32'h0000_0000;
		end else if (link.syncTick) begin
			usCnt_q <= 6'h00;
			// A recent local wrap already counted this microsecond
			if (usCnt_q >= SYNC_HALF) begin
				timeUs_q <= timeUs_q + 32'h0000_0001;
			end
		end else if (usCnt_q == SYNC_LAST) begin
			usCnt_q <= 6'h00;
			timeUs_q <= timeUs_q + 32'h0000_0001;
		end else begin
			usCnt_q <= usCnt_q + 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// Byte sources
	// ----------------------------------------------------------------
	// Byte 0 is the top byte: address first, then slice hi and lo
	assign hdrWord = {MAC_ADDR, sliceCnt_q};
	assign hdrByte = hdrWord[{~idx_q[2:0], 3'b000} +: 8];

	// Time stamp and data are snapshotted when byte 0 goes out
	always_comb begin
		case (idx_q)
			`DCF_PKT_LEN_POS: pktByte = {4'h0, `DCF_PKT_LEN};
			`DCF_PKT_CTR_POS: pktByte = ctr_q;
			`DCF_PKT_PID_POS: pktByte = PKT_ID;
			`DCF_PKT_FILL_POS: pktByte = `DCF_FILL_BYTE;
			4'h4: pktByte = pktTs_q[31:24];
			4'h5: pktByte = pktTs_q[23:16];
			4'h6: pktByte = pktTs_q[15:8];
			4'h7: pktByte = pktTs_q[7:0];
			4'h8: pktByte = pktData_q[31:24];
			4'h9: pktByte = pktData_q[23:16];
			4'ha: pktByte = pktData_q[15:8];
			4'hb: pktByte = pktData_q[7:0];
			default: pktByte = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pktTs_q <= 32'h0000_0000;
			pktData_q <= 32'h0000_0000;
			ctr_q <= `DCF_CTR_RST;
		end else if (state_q == dcf_pkg::DCF_PKT) begin
			if (idx_q == 4'h0) begin
				pktTs_q <= timeUs_q;
				pktData_q <= measData;
			end
			if (idx_q == `DCF_PKT_LEN - 4'h1) begin
				ctr_q <= ctr_q + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	// Upstream bytes during our packet are lost; planning prevents it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= dcf_pkg::DCF_IDLE;
			idx_q <= 4'h0;
			link.frmValid <= 1'b0;
			link.frmFirst <= 1'b0;
			link.frmLast <= 1'b0;
			link.frmData <= 8'h00;
		end else begin
			case (state_q)
				dcf_pkg::DCF_IDLE: begin
					link.frmFirst <= 1'b0;
					link.frmLast <= 1'b0;
					link.frmValid <= 1'b0;
					idx_q <= 4'h0;
					if (isLast && sliceTick_q) begin
						state_q <= dcf_pkg::DCF_HDR;
					end else if (!isLast && upValid) begin
						link.frmValid <= 1'b1;
						link.frmFirst <= upFirst;
						link.frmData <= upData;
						if (upLast && hit) begin
							state_q <= dcf_pkg::DCF_PKT;
						end else begin
							link.frmLast <= upLast;
						end
					end
				end
				dcf_pkg::DCF_HDR: begin
					link.frmValid <= 1'b1;
					link.frmFirst <= (idx_q == 4'h0);
					link.frmData <= hdrByte;
					link.frmLast <= 1'b0;
					if (idx_q == `DCF_HDR_LEN - 4'h1) begin
						idx_q <= 4'h0;
						if (hit) begin
							state_q <= dcf_pkg::DCF_PKT;
						end else begin
							link.frmLast <= 1'b1;
							state_q <= dcf_pkg::DCF_IDLE;
						end
					end else begin
						idx_q <= idx_q + 4'h1;
					end
				end
				dcf_pkg::DCF_PKT: begin
					link.frmValid <= 1'b1;
					link.frmFirst <= 1'b0;
					link.frmData <= pktByte;
					link.frmLast <= (idx_q == `DCF_PKT_LEN - 4'h1);
					if (idx_q == `DCF_PKT_LEN - 4'h1) begin
						idx_q <= 4'h0;
						state_q <= dcf_pkg::DCF_IDLE;
					end else begin
						idx_q <= idx_q + 4'h1;
					end
				end
				default: begin
					state_q <= dcf_pkg::DCF_IDLE;
					link.frmValid <= 1'b0;
					link.frmFirst <= 1'b0;
					link.frmLast <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Control path from the PC and slice status
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctlOutValid <= 1'b0;
			ctlOutData <= 8'h00;
			sliceNum <= 16'h0000;
		end else begin
			ctlOutValid <= link.ctlValid;
			ctlOutData <= link.ctlData;
			sliceNum <= curSlice;
		end
	end
endmodule

// [logic/dcf_pc_end.sv]
`timescale 1ns/1ps
`include "dcf_regs.svh"

module dcf_pc_end (
	input wire logic sys_clk,
	input wire logic arst_n,
	dcf_link_if.host link,
	input wire logic syncSource,
	input wire logic ctlInValid,
	input wire logic [7:0] ctlInData,
	output logic rxValid,
	output logic rxFirst,
	output logic rxLast,
	output logic [7:0] rxData,
	output logic [15:0] rxSlice,
	output logic [15:0] rxFrameLen
);
	localparam logic [5:0] SYNC_LAST = 6'(`DCF_SYNC_CYC - 1);

	logic [5:0] syncCnt_q;
	logic [3:0] pos_q;
	logic [15:0] len_q;
	logic [3:0] curPos;

	// ----------------------------------------------------------------
	// Sync source: one tick per microsecond
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			syncCnt_q <= 6'h00;
			link.syncTick <= 1'b0;
		end else if (!syncSource) begin
			syncCnt_q <= 6'h00;
			link.syncTick <= 1'b0;
		end else if (syncCnt_q == SYNC_LAST) begin
			syncCnt_q <= 6'h00;
			link.syncTick <= 1'b1;
		end else begin
			syncCnt_q <= syncCnt_q + 6'h01;
			link.syncTick <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Control bytes toward the chain, independent of frames
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			link.ctlValid <= 1'b0;
			link.ctlData <= 8'h00;
		end else begin
			link.ctlValid <= ctlInValid;
			link.ctlData <= ctlInData;
		end
	end

	// ----------------------------------------------------------------
	// Frame reception
	// ----------------------------------------------------------------
	assign curPos = link.frmFirst ? 4'h0 : pos_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pos_q <= 4'h0;
			len_q <= 16'h0000;
			rxValid <= 1'b0;
			rxFirst <= 1'b0;
			rxLast <= 1'b0;
			rxData <= 8'h00;
			rxSlice <= 16'h0000;
			rxFrameLen <= 16'h0000;
		end else begin
			rxValid <= link.frmValid;
			rxFirst <= link.frmValid && link.frmFirst;
			rxLast <= link.frmValid && link.frmLast;
			if (link.frmValid) begin
				rxData <= link.frmData;
				pos_q <= (curPos == 4'hf) ? 4'hf : curPos + 4'h1;
				len_q <= link.frmFirst ? 16'h0001 : len_q + 16'h0001;
				if (curPos == `DCF_SLICE_HI_POS) begin
					rxSlice[15:8] <= link.frmData;
				end
				if (curPos == `DCF_SLICE_LO_POS) begin
					rxSlice[7:0] <= link.frmData;
				end
				if (link.frmLast) begin
					// Total length shows each appended packet
					rxFrameLen <= link.frmFirst ? 16'h0001
						: len_q + 16'h0001;
				end
			end
		end
	end
endmodule

// [tb/dcf_link_props.sv]
`timescale 1ns/1ps
`include "dcf_regs.svh"

module dcf_link_props (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic frmValid,
	input wire logic frmFirst,
	input wire logic frmLast,
	input wire logic [7:0] frmData,
	input wire logic ctlValid,
	input wire logic [7:0] ctlData,
	input wire logic syncTick
);
	// ----
	// Helper counters
	// ----
	logic [7:0] nbCnt_q;
	logic [7:0] tickCnt_q;
	logic tickSeen_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Byte index within the current frame
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			nbCnt_q <= 8'h00;
		end else if (frmValid) begin
			nbCnt_q <= frmLast ? 8'h00 : nbCnt_q + 8'h01;
		end
	end

	// Saturates so a stopped source never wraps into a false period
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tickCnt_q <= 8'h00;
			tickSeen_q <= 1'b0;
		end else if (syncTick) begin
			tickCnt_q <= 8'h00;
			tickSeen_q <= 1'b1;
		end else if (tickCnt_q != 8'hff) begin
			tickCnt_q <= tickCnt_q + 8'h01;
		end
	end

	// ----
	// Properties
	// ----
	property p_first;
		frmFirst |-> frmValid && nbCnt_q == 8'h00;
	endproperty
	a_first: assert property (p_first) else $error("first misplaced");

	property p_last;
		frmLast |-> frmValid;
	endproperty
	a_last: assert property (p_last) else $error("last without valid");

	property p_mac;
		frmFirst |-> frmData == 8'h02 ##1
			(frmValid && frmData == 8'h00)[*4] ##1 frmData == 8'h01;
	endproperty
	a_mac: assert property (p_mac) else $error("station address wrong");

	property p_contig;
		frmValid && !frmLast |=> frmValid;
	endproperty
	a_contig: assert property (p_contig) else $error("frame gap");

	property p_gap;
		frmLast |=> !frmValid;
	endproperty
	a_gap: assert property (p_gap) else $error("no gap after frame");

	property p_len;
		frmLast |-> nbCnt_q >= 8'h07
			&& ((nbCnt_q - 8'h07) % 8'h0c) == 8'h00;
	endproperty
	a_len: assert property (p_len) else $error("frame length");

	property p_pkt_len;
		frmValid && nbCnt_q == 8'h08 |-> frmData == 8'h0c;
	endproperty
	a_pkt_len: assert property (p_pkt_len) else $error("packet len");

	property p_fill;
		frmValid && nbCnt_q == 8'h0b |-> frmData == `DCF_FILL_BYTE;
	endproperty
	a_fill: assert property (p_fill) else $error("fill byte");

	property p_sync_period;
		syncTick && tickSeen_q |-> tickCnt_q == 8'(`DCF_SYNC_CYC - 1);
	endproperty
	a_sync_period: assert property (p_sync_period) else $error("sync period");

	property p_sync_pulse;
		syncTick |=> !syncTick;
	endproperty
	a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse");

	c_short: cover property (frmLast && nbCnt_q == 8'h07);
	c_long: cover property (frmLast && nbCnt_q == 8'h13);
	c_sync: cover property (syncTick && tickSeen_q);
	c_ctl: cover property (ctlValid ##1 ctlValid);
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps

module tb;
	logic sys_clk = 0, arst_n = 0, upValid = 0, upFirst = 0, upLast = 0;
	logic isLast = 1, genEnable = 1, ctlInValid = 0;
	logic [7:0] upData = 8'h00, ctlInData = 8'h00, ctlOutData, rxData;
	logic [15:0] slicePeriod = 16'h00c8, slotMask = 16'h0005;
	logic [31:0] measData = 32'ha1b2c3d4;
	logic ctlOutValid, rxValid, rxFirst, rxLast;
	logic [15:0] sliceNum, rxSlice, rxFrameLen;
	logic [7:0] fb [0:63];
	int err_total = 0, checked = 0, n;
	int cyc = 0, t0 = 0;

	dcf_link_if link();
	dcf_chain_module dcf_chain_module_inst (.sys_clk(sys_clk),
		.arst_n(arst_n), .link(link), .upValid(upValid), .upFirst(upFirst),
		.upLast(upLast), .upData(upData), .isLast(isLast),
		.genEnable(genEnable), .slicePeriod(slicePeriod),
		.slotMask(slotMask), .measData(measData), .ctlOutValid(ctlOutValid),
		.ctlOutData(ctlOutData), .sliceNum(sliceNum));
	dcf_pc_end dcf_pc_end_inst (.sys_clk(sys_clk), .arst_n(arst_n),
		.link(link), .syncSource(1'b1), .ctlInValid(ctlInValid),
		.ctlInData(ctlInData), .rxValid(rxValid), .rxFirst(rxFirst),
		.rxLast(rxLast), .rxData(rxData), .rxSlice(rxSlice),
		.rxFrameLen(rxFrameLen));
	dcf_link_props dcf_link_props_inst (.sys_clk(sys_clk), .arst_n(arst_n),
		.frmValid(link.frmValid), .frmFirst(link.frmFirst),
		.frmLast(link.frmLast), .frmData(link.frmData),
		.ctlValid(link.ctlValid), .ctlData(link.ctlData),
		.syncTick(link.syncTick));

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
	end

	// ----
	// Shared tasks
	// ----
	task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic conclude();
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Collects one frame from the PC end; settles one edge past rxLast
	task automatic get_frame();
		bit done;
		done = 0;
		n = 0;
		for (int i = 0; i < 2000 && !done; i++) begin
			@(posedge sys_clk);
			#1;
			if (rxValid === 1'b1 && n < 64) begin
				if (n == 0) begin
					t0 = cyc;
					cmp("rxFirst", 32'h1, 32'(rxFirst));
				end
				fb[n] = rxData;
				n++;
				done = (rxLast === 1'b1);
			end
		end
		if (!done) begin
			err_total++;
			conclude();
		end
		@(posedge sys_clk);
		#1;
	endtask

	task automatic drive_up(logic [15:0] s);
		logic [7:0] h [0:7];
		h = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, s[15:8], s[7:0]};
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			#1;
			upValid = 1;
			upFirst = (i == 0);
			upLast = (i == 7);
			upData = h[i];
		end
		@(posedge sys_clk);
		#1;
		upValid = 0;
		upLast = 0;
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_slices();
		int tPrev;
		logic [31:0] ts0, ts1;
		tPrev = 0;
		ts0 = 32'h0;
		for (int k = 0; k < 4; k++) begin
			get_frame();
			ts1 = {fb[12], fb[13], fb[14], fb[15]};
			if (k > 0) begin
				cmp("period", 32'(slicePeriod), 32'(t0 - tPrev));
			end
			// Two slices of 20 ns cycles, counted in microseconds
			if (k == 2) begin
				cmp("stamp", 32'(slicePeriod) / 32'd25, ts1 - ts0);
			end
			if (k == 0) begin
				ts0 = ts1;
			end
			tPrev = t0;
			cmp("slice", 32'(k), 32'(rxSlice));
			cmp("sliceNum", 32'(k), 32'(sliceNum));
			cmp("len", (k % 2 == 0) ? 32'd20 : 32'd8, 32'(rxFrameLen));
			cmp("bytes", (k % 2 == 0) ? 32'd20 : 32'd8, 32'(n));
			if (k % 2 == 0) begin
				cmp("ctr", 32'(k / 2), 32'(fb[9]));
				cmp("pid", 32'h01, 32'(fb[10]));
				cmp("data", measData, {fb[16], fb[17], fb[18], fb[19]});
			end
		end
	endtask

	task automatic t_ctl();
		@(posedge sys_clk);
		#1;
		ctlInValid = 1;
		ctlInData = 8'h5a;
		@(posedge sys_clk);
		#1;
		ctlInData = 8'ha5;
		@(posedge sys_clk);
		#1;
		ctlInValid = 0;
		cmp("ctl0", 32'h15a, {23'h0, ctlOutValid, ctlOutData});
		@(posedge sys_clk);
		#1;
		cmp("ctl1", 32'h1a5, {23'h0, ctlOutValid, ctlOutData});
		@(posedge sys_clk);
		#1;
		cmp("ctlIdle", 32'h0, 32'(ctlOutValid));
	endtask

	// Generator switched off must leave the link silent
	task automatic t_off();
		int cnt;
		cnt = 0;
		get_frame();
		genEnable = 0;
		for (int i = 0; i < 400; i++) begin
			@(posedge sys_clk);
			#1;
			if (rxValid !== 1'b0) begin
				cnt++;
			end
		end
		cmp("idle", 32'h0, 32'(cnt));
	endtask

	// Forwarded frame takes its slice from the header only
	task automatic t_fwd();
		logic [15:0] s;
		isLast = 0;
		genEnable = 1;
		for (int k = 0; k < 2; k++) begin
			s = 16'h0012 + 16'(k);
			fork
				drive_up(s);
				get_frame();
			join
			cmp("fwdSlice", 32'(s), 32'(rxSlice));
			cmp("fwdNum", 32'(s), 32'(sliceNum));
			cmp("fwdLen", (k == 0) ? 32'd20 : 32'd8, 32'(rxFrameLen));
			cmp("fwdLo", 32'(s[7:0]), 32'(fb[7]));
		end
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		#1;
		arst_n = 1;
		t_slices();
		t_ctl();
		t_off();
		t_fwd();
		conclude();
	end
endmodule
